// ### inc/rail_seq_regs.svh
// Register map, reset values and timing figures of the rail sequencer
`ifndef RAIL_SEQ_REGS_SVH
`define RAIL_SEQ_REGS_SVH

`define GAP_LOW_ADDR     8'h20
`define GAP_HIGH_ADDR    8'h21
`define SLOT_ADDR        8'h22

`define GAP_LOW_RST      8'h00
`define GAP_HIGH_RST     8'h00
`define SLOT_RST         8'h98

`define GAP9_BIT         0
`define PD_SCALE_BIT     7
`define BUCK_ONE_LSB     0
`define BUCK_TWO_LSB     4

`define SLOT_FIRST       4'h3
`define SLOT_LAST        4'ha
`define STROBE_COUNT     10

`define GAP_SHORT_US     2000
`define GAP_LONG_US      5000
`define CLK_MHZ          200
`define PD_SCALE         10

`endif

// ### inc/rail_seq_pkg.sv
// Types shared by the rail sequencer modules
package rail_seq_pkg;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b001,
        S_STROBE = 3'b010,
        S_WAIT   = 3'b100
    } seq_state_t;

    typedef logic [9:0] strobe_vec_t;

endpackage

// ### inc/gap_timer_if.sv
// Start, length and expiry of one inter-strobe gap
`timescale 1ns/1ps
interface gap_timer_if #(parameter int CNT_W = 24);
    logic             start;
    logic [CNT_W-1:0] cycles;
    logic             done;

    modport ctl (output start, output cycles, input done);
    modport tmr (input start, input cycles, output done);
endinterface

// ### core/gap_timer.sv
// Down-counter that times one gap between two strobes
`timescale 1ns/1ps
module gap_timer
    import rail_seq_pkg::*;
#(
    parameter int CNT_W = 24
)(
    input  wire logic   mclk_i,
    input  wire logic   rst_n_i,
    gap_timer_if.tmr    tif
);
    logic [CNT_W-1:0] cnt_r;
    logic             run_r;
    logic [CNT_W-1:0] el_r;
    logic [CNT_W-1:0] len_r;

    // Done one cycle early so the strobe spacing equals the length
    assign tif.done = run_r && (cnt_r == CNT_W'(1));

    // Load and count down; lengths below two are not supported
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end
        else if (tif.start)
        begin
            cnt_r <= tif.cycles - CNT_W'(1);
            run_r <= 1'b1;
        end
        else if (tif.done)
            run_r <= 1'b0;
        else if (run_r)
            cnt_r <= cnt_r - CNT_W'(1);
    end

    // Elapsed-cycle helper read only by the check below
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            el_r  <= '0;
            len_r <= '0;
        end
        else if (tif.start)
        begin
            el_r  <= CNT_W'(1);
            len_r <= tif.cycles;
        end
        else if (run_r)
            el_r <= el_r + CNT_W'(1);
    end

    gap_length_a: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tif.done |-> el_r == len_r - CNT_W'(1))
        else $error("gap timer expired at wrong count");
endmodule

// ### core/rail_seq.sv
// Ten-slot strobe sequencer with gap delays and buck rail slots
// Overview of operation
// - Ten strobes, nine delays between them
// - Gap bit zero two ms, one five
// - Gaps one to eight in first register
// - Gap nine bit zero; bits 6-1 zero
// - Scale bit stretches power-down gaps tenfold
// - Power-up gaps never scaled
// - Gap registers reset to zero
// - Slot register resets to 98h
`timescale 1ns/1ps
`include "rail_seq_regs.svh"
module rail_seq
    import rail_seq_pkg::*;
#(
    parameter int CNT_W     = 24,
    parameter int SHORT_CYC = `GAP_SHORT_US * `CLK_MHZ,
    parameter int LONG_CYC  = `GAP_LONG_US * `CLK_MHZ
)(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        unlock_ok_i,
    input  wire logic        pwr_up_req_i,
    input  wire logic        pwr_dn_req_i,
    output strobe_vec_t      strobe_o,
    output logic             buck_one_en_o,
    output logic             buck_two_en_o,
    output logic             busy_o
);
    localparam int SHORT_PD = SHORT_CYC * `PD_SCALE;
    localparam int LONG_PD  = LONG_CYC * `PD_SCALE;

    logic [7:0]  gap_low_r;
    logic        gap9_r;
    logic        scale_r;
    logic [7:0]  slot_reg_r;
    logic [7:0]  rdata_r;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [3:0]  slot_r;
    logic [3:0]  slot_nxt;
    logic        dir_r;
    strobe_vec_t strobe_r;
    logic        one_en_r;
    logic        two_en_r;

    gap_timer_if #(.CNT_W(CNT_W)) tif ();

    gap_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .tif     (tif)
    );

    // Register decode; a locked write is dropped silently
    wire wr_ok   = reg_wr_i && unlock_ok_i;
    wire wr_low  = wr_ok && (reg_addr_i == `GAP_LOW_ADDR);
    wire wr_high = wr_ok && (reg_addr_i == `GAP_HIGH_ADDR);
    wire wr_slot = wr_ok && (reg_addr_i == `SLOT_ADDR);
    wire [7:0] high_view = {scale_r, 6'h00, gap9_r};
    wire [7:0] rd_val =
        (reg_addr_i == `GAP_LOW_ADDR)  ? gap_low_r  :
        (reg_addr_i == `GAP_HIGH_ADDR) ? high_view  :
        (reg_addr_i == `SLOT_ADDR)     ? slot_reg_r : 8'h00;

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            gap_low_r  <= `GAP_LOW_RST;
            gap9_r     <= 1'(`GAP_HIGH_RST >> `GAP9_BIT);
            scale_r    <= 1'(`GAP_HIGH_RST >> `PD_SCALE_BIT);
            slot_reg_r <= `SLOT_RST;
        end
        else
        begin
            if (wr_low)
                gap_low_r <= reg_wdata_i;
            if (wr_high)
            begin
                gap9_r  <= reg_wdata_i[`GAP9_BIT];
                scale_r <= reg_wdata_i[`PD_SCALE_BIT];
            end
            if (wr_slot)
                slot_reg_r <= reg_wdata_i;
        end
    end

    // Read data held until the next read strobe
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
            rdata_r <= 8'h00;
        else if (reg_rd_i)
            rdata_r <= rd_val;
    end

    wire [3:0] one_code = slot_reg_r[`BUCK_ONE_LSB +: 4];
    wire [3:0] two_code = slot_reg_r[`BUCK_TWO_LSB +: 4];
    wire one_ctl = one_code >= `SLOT_FIRST && one_code <= `SLOT_LAST;
    wire two_ctl = two_code >= `SLOT_FIRST && two_code <= `SLOT_LAST;
    wire strobe_vec_t one_mask =
        one_ctl ? strobe_vec_t'(10'h001 << (one_code - 4'h1)) : '0;
    wire strobe_vec_t two_mask =
        two_ctl ? strobe_vec_t'(10'h001 << (two_code - 4'h1)) : '0;
    wire strobe_vec_t cur_bit = strobe_vec_t'(10'h001 << (slot_r - 4'h1));

    // gap index follows the walk direction
    wire [3:0] gap_idx  = dir_r ? slot_r - 4'h1 : slot_r;
    wire [8:0] gap_sel  = {gap9_r, gap_low_r};
    wire       gap_long = gap_sel[gap_idx - 4'h1];
    wire       stretch  = dir_r && scale_r;
    wire [CNT_W-1:0] gap_cyc =
        stretch ? (gap_long ? CNT_W'(LONG_PD) : CNT_W'(SHORT_PD)) :
                  (gap_long ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC));
    wire last_slot = dir_r ? (slot_r == 4'h1)
                           : (slot_r == 4'(`STROBE_COUNT));

    assign tif.start  = (state_r == S_STROBE) && !last_slot;
    assign tif.cycles = gap_cyc;

    always_comb
    begin
        state_nxt = state_r;
        slot_nxt  = slot_r;
        unique case (state_r)
            S_IDLE:
            begin
                if (pwr_up_req_i)
                begin
                    state_nxt = S_STROBE;
                    slot_nxt  = 4'h1;
                end
                else if (pwr_dn_req_i)
                begin
                    state_nxt = S_STROBE;
                    slot_nxt  = 4'(`STROBE_COUNT);
                end
            end
            S_STROBE:
                state_nxt = last_slot ? S_IDLE : S_WAIT;
            S_WAIT:
                if (tif.done)
                begin
                    state_nxt = S_STROBE;
                    slot_nxt  = dir_r ? slot_r - 4'h1 : slot_r + 4'h1;
                end
            default:
                state_nxt = S_IDLE;
        endcase
    end

    // Requests during a walk are ignored, up wins a tie
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= S_IDLE;
            slot_r  <= 4'h1;
            dir_r   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            slot_r  <= slot_nxt;
            if (state_r == S_IDLE)
                dir_r <= !pwr_up_req_i && pwr_dn_req_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            strobe_r <= '0;
            one_en_r <= 1'b0;
            two_en_r <= 1'b0;
        end
        else
        begin
            strobe_r <= (state_r == S_STROBE) ? cur_bit : '0;
            if (state_r == S_STROBE && (one_mask & cur_bit) != '0)
                one_en_r <= !dir_r;
            if (state_r == S_STROBE && (two_mask & cur_bit) != '0)
                two_en_r <= !dir_r;
        end
    end

    assign reg_rdata_o   = rdata_r;
    assign strobe_o      = strobe_r;
    assign buck_one_en_o = one_en_r;
    assign buck_two_en_o = two_en_r;
    assign busy_o        = state_r != S_IDLE;

    // Last strobe seen and its direction, for the checks only
    strobe_vec_t last_r;
    logic        last_dn_r;
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            last_r    <= '0;
            last_dn_r <= 1'b0;
        end
        else if (strobe_r != '0)
        begin
            last_r    <= strobe_r;
            last_dn_r <= dir_r;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    up_order_a: assert property (
        strobe_r != '0 && !dir_r && strobe_r != 10'h001
        |-> last_r == (strobe_r >> 1) && !last_dn_r)
        else $error("power-up strobe out of order");

    dn_order_a: assert property (
        strobe_r != '0 && dir_r && strobe_r != 10'h200
        |-> last_r == (strobe_r << 1) && last_dn_r)
        else $error("power-down strobe out of order");

    dn_scale_a: assert property (
        tif.start && dir_r && scale_r
        |-> tif.cycles == (gap_sel[slot_r - 4'h2] ? CNT_W'(LONG_PD)
                                                  : CNT_W'(SHORT_PD)))
        else $error("power-down gap not scaled");

    up_plain_a: assert property (
        tif.start && !dir_r
        |-> tif.cycles == (gap_sel[slot_r - 4'h1] ? CNT_W'(LONG_CYC)
                                                  : CNT_W'(SHORT_CYC)))
        else $error("power-up gap scaled");

    low_write_a: assert property (
        wr_low |=> gap_low_r == $past(reg_wdata_i))
        else $error("gap register write lost");

    high_read_a: assert property (
        reg_rd_i && reg_addr_i == `GAP_HIGH_ADDR
        |=> reg_rdata_o == {$past(scale_r), 6'h00, $past(gap9_r)})
        else $error("reserved bits not zero");

    // second buck rail on at its slot
    two_on_a: assert property (
        strobe_r != '0 && !dir_r && (strobe_r & two_mask) != '0
        |-> buck_two_en_o)
        else $error("second buck rail not enabled");

    // first buck rail off at its slot
    one_off_a: assert property (
        strobe_r != '0 && dir_r && (strobe_r & one_mask) != '0
        |-> !buck_one_en_o)
        else $error("first buck rail not disabled");

    gap_reset_a: assert property (
        $past(!rst_n_i) |-> gap_low_r == 8'h00 && !gap9_r && !scale_r)
        else $error("gap registers not reset");

    slot_reset_a: assert property (
        $past(!rst_n_i) |-> slot_reg_r == 8'h98)
        else $error("slot register not reset");

    locked_a: assert property (
        reg_wr_i && !unlock_ok_i
        |=> $stable(gap_low_r) && $stable(slot_reg_r) && $stable(high_view))
        else $error("write accepted while locked");

    up_done_c: cover property (strobe_r == 10'h200 && !dir_r);
    dn_done_c: cover property (strobe_r == 10'h001 && dir_r);
    scaled_c:  cover property (tif.start && stretch);
    locked_c:  cover property (reg_wr_i && !unlock_ok_i);
endmodule

// ### testbench/rail_seq_tb.sv
// Self-checking bench for the rail strobe sequencer
`timescale 1ns/1ps
module rail_seq_tb
    import rail_seq_pkg::*;
;
    localparam int SHORT = 4;
    localparam int LONG  = 7;

    logic        clk    = 1'b0;
    logic        rst_n  = 1'b0;
    logic [7:0]  addr   = 8'h00;
    logic        wr_s   = 1'b0;
    logic [7:0]  wdata  = 8'h00;
    logic        rd_s   = 1'b0;
    logic [7:0]  rdata;
    logic        unlock = 1'b0;
    logic        up_req = 1'b0;
    logic        dn_req = 1'b0;
    strobe_vec_t strobe;
    logic        en1;
    logic        en2;
    logic        busy;
    int          mismatches  = 0;
    int          comparisons = 0;
    // Mirror of register contents and expected rail levels
    logic [7:0]  g_lo;
    logic [7:0]  g_hi;
    logic [7:0]  slot;
    logic        exp1 = 1'b0;
    logic        exp2 = 1'b0;

    // Half period 2.5 ns gives 200 MHz
    always #2.5 clk = ~clk;

    // Short gap counts keep the scaled walks to a few hundred cycles
    rail_seq #(
        .CNT_W     (8),
        .SHORT_CYC (SHORT),
        .LONG_CYC  (LONG)
    ) i_rail_seq (
        .mclk_i        (clk),
        .rst_n_i       (rst_n),
        .reg_addr_i    (addr),
        .reg_wr_i      (wr_s),
        .reg_wdata_i   (wdata),
        .reg_rd_i      (rd_s),
        .reg_rdata_o   (rdata),
        .unlock_ok_i   (unlock),
        .pwr_up_req_i  (up_req),
        .pwr_dn_req_i  (dn_req),
        .strobe_o      (strobe),
        .buck_one_en_o (en1),
        .buck_two_en_o (en2),
        .busy_o        (busy)
    );

    // Shared compare, case equality so unknowns fail
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // One write cycle, unlock level given by the caller
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic ok);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        unlock <= ok;
        @(posedge clk);
        wr_s <= 1'b0;
        unlock <= 1'b0;
    endtask

    // Read strobe, data settles one cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(16'(rdata), 16'(e), what);
    endtask

    // One walk; an opposite request mid-walk must be dropped
    task automatic walk(input logic up);
        int n;
        int last;
        int k;
        int c;
        logic [8:0] sel;
        n = 0;
        // Request is driven one edge before cycle zero of the loop
        last = -1;
        sel = {g_hi[0], g_lo};
        @(posedge clk);
        up_req <= up;
        dn_req <= !up;
        @(posedge clk);
        up_req <= 1'b0;
        dn_req <= 1'b0;
        for (int cyc = 1; cyc < 2000 && n < 10; cyc++)
        begin
            @(posedge clk);
            if (cyc == 5)
            begin
                up_req <= !up;
                dn_req <= up;
            end
            if (cyc == 6)
            begin
                up_req <= 1'b0;
                dn_req <= 1'b0;
            end
            #1;
            if (cyc == 1)
                check(16'(busy), 16'h1, "busy start");
            if (strobe !== 10'h000)
            begin
                k = up ? n + 1 : 10 - n;
                check(16'(strobe), 16'h1 << (k - 1), "order");
                // First strobe comes two cycles after the request
                if (n == 0)
                    c = 2;
                else
                    c = sel[up ? k - 2 : k - 1] ? LONG : SHORT;
                if (n != 0 && !up && g_hi[7])
                    c = c * 10;
                check(16'(cyc - last), 16'(c), "gap");
                // Codes outside 3h to Ah leave the rail alone
                if (k >= 3 && slot[3:0] == 4'(k))
                    exp1 = up;
                if (k >= 3 && slot[7:4] == 4'(k))
                    exp2 = up;
                check(16'(en1), 16'(exp1), "rail one");
                check(16'(en2), 16'(exp2), "rail two");
                check(16'(busy), 16'(n < 9), "busy");
                last = cyc;
                n++;
            end
        end
        check(16'(n), 16'd10, "strobe count");
        repeat (3) @(posedge clk);
        #1;
        check(16'(busy), 16'h0, "request not queued");
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h20, 8'h00, "gap low reset");
        rd(8'h21, 8'h00, "gap high reset");
        rd(8'h22, 8'h98, "slot reset");
        rd(8'h30, 8'h00, "unmapped");
        $display("test reset values done");
        wr(8'h22, 8'h35, 1'b0);
        rd(8'h22, 8'h98, "locked write");
        wr(8'h20, 8'ha5, 1'b1);
        wr(8'h21, 8'hff, 1'b1);
        wr(8'h22, 8'ha3, 1'b1);
        rd(8'h20, 8'ha5, "gap low");
        rd(8'h21, 8'h81, "reserved zero");
        rd(8'h22, 8'ha3, "slot");
        g_lo = 8'ha5;
        g_hi = 8'h81;
        slot = 8'ha3;
        $display("test registers done");
        walk(1'b1);
        $display("test power-up with scale set done");
        wr(8'h22, 8'h4b, 1'b1);
        slot = 8'h4b;
        walk(1'b0);
        $display("test scaled power-down done");
        // Second buck code 1h is outside sequencer control
        wr(8'h21, 8'h01, 1'b1);
        wr(8'h22, 8'h15, 1'b1);
        g_hi = 8'h01;
        slot = 8'h15;
        walk(1'b1);
        walk(1'b0);
        walk(1'b1);
        $display("test unscaled walks done");
        // Mid-run reset with the first rail on
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check(16'({en1, en2, busy}), 16'h0, "rails reset");
        check(16'(strobe), 16'h0, "strobe reset");
        rd(8'h20, 8'h00, "gap low reset again");
        rd(8'h21, 8'h00, "gap high reset again");
        rd(8'h22, 8'h98, "slot reset again");
        g_lo = 8'h00;
        g_hi = 8'h00;
        slot = 8'h98;
        exp1 = 1'b0;
        exp2 = 1'b0;
        walk(1'b1);
        $display("test mid-run reset done");
        test_done;
    end

    // Watchdog, walks need a few thousand cycles at most
    initial
    begin
        #100000;
        mismatches++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        test_done;
    end
endmodule
